// ---- hdl/standby_pkg.sv ----
// Shared constants and types for the standby mode controller
package standby_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W        = 16;
   localparam int          DATA_W        = 8;
   localparam int          SEL_W         = 3;
   localparam logic [15:0] SETTLE_ADDR   = 16'hfffa;
   localparam logic [2:0]  SEL_RESET     = 3'h4;
   localparam int          SEL_LSB       = 0;

   // ---------------------------------------------------------------
   // Settle select codes
   // ---------------------------------------------------------------
   localparam logic [2:0]  SEL_EXP12     = 3'h0;
   localparam logic [2:0]  SEL_EXP14     = 3'h1;
   localparam logic [2:0]  SEL_EXP15     = 3'h2;
   localparam logic [2:0]  SEL_EXP16     = 3'h7;
   localparam logic [2:0]  SEL_EXP17     = 3'h4;

   // ---------------------------------------------------------------
   // Counter and latency figures
   // ---------------------------------------------------------------
   localparam int          EXP_W         = 5;
   localparam int          CNT_W         = 18;
   localparam int          EXP12_DEF     = 12;
   localparam int          EXP14_DEF     = 14;
   localparam int          EXP15_DEF     = 15;
   localparam int          EXP16_DEF     = 16;
   localparam int          EXP17_DEF     = 17;
   localparam int          LAT_W         = 4;
   localparam logic [3:0]  LAT_SERVICE   = 4'h8;
   localparam logic [3:0]  LAT_RESUME    = 4'h2;
   localparam logic [3:0]  LAT_AFTER_SET = 4'h1;

   // ---------------------------------------------------------------
   // Controller states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_RUN,
      ST_HALT,
      ST_STOP,
      ST_SETTLE
   } standby_state_t;

endpackage

// ---- hdl/settle_if.sv ----
// Carrier between the controller and its settle timer
`timescale 1ns/1ps
interface settle_if;
   import standby_pkg::*;

   logic             clear;
   logic             count;
   logic [EXP_W-1:0] exp_sel;
   logic             done;

   modport ctrl  (output clear, output count, output exp_sel, input done);
   modport timer (input clear, input count, input exp_sel, output done);
endinterface

// ---- hdl/settle_timer.sv ----
// Oscillation settle counter of main-clock cycles
`timescale 1ns/1ps
module settle_timer
   import standby_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Controller side
   settle_if.timer   sif
);
   import standby_pkg::*;

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] last;
   logic             done_q;
   logic             done_d;

   always_comb begin
      last   = CNT_W'((CNT_W+1)'(1) << sif.exp_sel) - CNT_W'(1);
      cnt_d  = cnt_q;
      done_d = 1'b0;
      if (sif.clear) begin
         cnt_d = '0;
      end else if (sif.count && !done_q) begin
         cnt_d = cnt_q + CNT_W'(1);
         // Done on the last of 2^n counted cycles
         if (cnt_q == last) begin
            done_d = 1'b1;
            cnt_d  = '0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         done_q <= done_d;
      end
   end

   assign sif.done = done_q;
endmodule

// ---- hdl/settle_sel_reg.sv ----
// Settle time select register on the documented data path
`timescale 1ns/1ps
module settle_sel_reg
   import standby_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Register access
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [DATA_W-1:0] reg_wdata,
   output      logic [DATA_W-1:0] reg_rdata,
   // Current code
   output      logic [SEL_W-1:0]  sel
);
   import standby_pkg::*;

   logic [SEL_W-1:0]  sel_q;
   logic [SEL_W-1:0]  sel_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic              hit;

   always_comb begin
      hit     = (reg_addr == SETTLE_ADDR);
      sel_d   = sel_q;
      rdata_d = rdata_q;
      // Upper five bits are not stored and read as zero
      if (hit && reg_wr) begin
         sel_d = reg_wdata[SEL_LSB +: SEL_W];
      end
      if (reg_rd) begin
         rdata_d = hit ? DATA_W'(sel_q) : '0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sel_q   <= SEL_RESET;
         rdata_q <= '0;
      end else begin
         sel_q   <= sel_d;
         rdata_q <= rdata_d;
      end
   end

   assign sel       = sel_q;
   assign reg_rdata = rdata_q;
endmodule

// ---- hdl/standby_mode_controller.sv ----
// Standby mode controller: HALT and STOP entry, wake-up and settle wait
//
// How it works
// - HALT instruction gates the CPU clock off; oscillator keeps running.
// - STOP instruction halts the main oscillator; whole system stops.
// - Registers, memory and port latches held unchanged in either standby mode.
// - In HALT the oscillator runs, CPU clock stops, port latches hold.
// - In HALT most peripherals run; converter and CAN unit stop.
// - Unmasked request leaves HALT; service if accepted, else next instruction.
// - HALT wake takes 8 clocks to service, 2 clocks to resume.
// - Non-maskable request leaves HALT and is always serviced.
// - Unmasked request releases STOP; settle wait precedes resumed processing.
// - 3-bit select picks 2^12, 2^14, 2^15, 2^16 or 2^17 cycles.
// - Reset loads the select register with 04h.
// - STOP release by reset always waits 2^17 cycles.
// - Settle count starts only once the oscillator is running.
// - STOP with an unmasked request pending skips STOP and goes straight to the settle wait.
// - Masked requests keep standby; reset releases either mode.
`timescale 1ns/1ps
module standby_mode_controller
   import standby_pkg::*;
#(
   parameter int EXP12 = EXP12_DEF,
   parameter int EXP14 = EXP14_DEF,
   parameter int EXP15 = EXP15_DEF,
   parameter int EXP16 = EXP16_DEF,
   parameter int EXP17 = EXP17_DEF
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   // Instruction decode
   input  wire logic              halt_exec,
   input  wire logic              stop_exec,
   // Interrupt state
   input  wire logic              irq_unmasked,
   input  wire logic              irq_accept_enable,
   input  wire logic              irq_priority_flag,
   input  wire logic              in_service_priority,
   input  wire logic              nmi_req,
   // Oscillator
   input  wire logic              osc_running,
   output      logic              osc_run_en,
   // Clock gates
   output      logic              cpu_clk_en,
   output      logic              periph_run_en,
   output      logic              adc_can_run_en,
   output      logic              port_latch_hold,
   // Wake indication to the core
   output      logic              wake_service,
   output      logic              wake_resume,
   // Register access
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [DATA_W-1:0] reg_wdata,
   output      logic [DATA_W-1:0] reg_rdata
);
   import standby_pkg::*;

   // ---------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------
   settle_if         sif ();
   logic [SEL_W-1:0] sel;

   settle_sel_reg u_sel (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .reg_addr  (reg_addr),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_wdata (reg_wdata),
      .reg_rdata (reg_rdata),
      .sel       (sel)
   );

   settle_timer u_timer (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .sif     (sif)
   );

   // ---------------------------------------------------------------
   // Oscillator status synchroniser
   // ---------------------------------------------------------------
   logic osc_meta_q;
   logic osc_ok_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         osc_meta_q <= 1'b0;
         osc_ok_q   <= 1'b0;
      end else begin
         osc_meta_q <= osc_running;
         osc_ok_q   <= osc_meta_q;
      end
   end

   // ---------------------------------------------------------------
   // Settle length decode
   // ---------------------------------------------------------------
   logic [EXP_W-1:0] sel_exp;

   always_comb begin
      // Prohibited codes fall back to the longest wait, the safe side
      unique case (sel)
         SEL_EXP12: sel_exp = EXP_W'(EXP12);
         SEL_EXP14: sel_exp = EXP_W'(EXP14);
         SEL_EXP15: sel_exp = EXP_W'(EXP15);
         SEL_EXP16: sel_exp = EXP_W'(EXP16);
         default:   sel_exp = EXP_W'(EXP17);
      endcase
   end

   // ---------------------------------------------------------------
   // Standby state machine
   // ---------------------------------------------------------------
   standby_state_t   state_q;
   standby_state_t   state_d;
   logic             rst_wait_q;
   logic             rst_wait_d;
   logic             svc_q;
   logic             svc_d;
   logic [LAT_W-1:0] lat_q;
   logic [LAT_W-1:0] lat_d;
   logic             wsvc_q;
   logic             wsvc_d;
   logic             wres_q;
   logic             wres_d;
   logic             wake_req;
   logic             svc_now;

   always_comb begin
      wake_req   = irq_unmasked || nmi_req;
      // Service needs acceptance and no higher-priority routine active
      svc_now    = nmi_req || (irq_accept_enable &&
                   (!irq_priority_flag || in_service_priority));
      state_d    = state_q;
      rst_wait_d = rst_wait_q;
      svc_d      = svc_q;
      lat_d      = lat_q;
      wsvc_d     = 1'b0;
      wres_d     = 1'b0;
      if (lat_q != '0) begin
         lat_d = lat_q - LAT_W'(1);
         if (lat_q == LAT_W'(1)) begin
            wsvc_d = svc_q;
            wres_d = !svc_q;
         end
      end
      unique case (state_q)
         ST_RUN: begin
            if (rst_wait_q) begin
               if (sif.done) begin
                  rst_wait_d = 1'b0;
               end
            end else if (lat_q == '0 && stop_exec) begin
               if (irq_unmasked) begin
                  state_d = ST_SETTLE;
               end else begin
                  state_d = ST_STOP;
               end
            end else if (lat_q == '0 && halt_exec) begin
               state_d = ST_HALT;
            end
         end
         ST_HALT: begin
            if (wake_req) begin
               state_d = ST_RUN;
               svc_d   = svc_now;
               lat_d   = svc_now ? LAT_SERVICE : LAT_RESUME;
            end
         end
         ST_STOP: begin
            if (irq_unmasked) begin
               state_d = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            if (sif.done) begin
               state_d = ST_RUN;
               svc_d   = svc_now;
               lat_d   = LAT_AFTER_SET;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ST_RUN;
         rst_wait_q <= 1'b1;
         svc_q      <= 1'b0;
         lat_q      <= '0;
         wsvc_q     <= 1'b0;
         wres_q     <= 1'b0;
      end else begin
         state_q    <= state_d;
         rst_wait_q <= rst_wait_d;
         svc_q      <= svc_d;
         lat_q      <= lat_d;
         wsvc_q     <= wsvc_d;
         wres_q     <= wres_d;
      end
   end

   // ---------------------------------------------------------------
   // Settle timer control
   // ---------------------------------------------------------------
   logic settling;

   always_comb begin
      settling    = (state_q == ST_SETTLE) || rst_wait_q;
      sif.clear   = !settling;
      // Start-up gap before oscillation is excluded from the count
      sif.count   = settling && osc_ok_q;
      sif.exp_sel = rst_wait_q ? EXP_W'(EXP17) : sel_exp;
   end

   // ---------------------------------------------------------------
   // Gates towards core and peripherals
   // ---------------------------------------------------------------
   always_comb begin
      osc_run_en      = (state_q != ST_STOP);
      cpu_clk_en      = (state_q == ST_RUN) && !rst_wait_q
                        && (lat_q == '0);
      periph_run_en   = (state_q != ST_STOP) && (state_q != ST_SETTLE);
      adc_can_run_en  = (state_q == ST_RUN) && !rst_wait_q;
      // Core state is frozen simply by its clock being off
      port_latch_hold = !cpu_clk_en;
      wake_service    = wsvc_q;
      wake_resume     = wres_q;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   sequence s_halt_ready;
      state_q == ST_HALT && wake_req;
   endsequence

   sequence s_halt_svc;
      s_halt_ready ##0 svc_now;
   endsequence

   sequence s_halt_res;
      s_halt_ready ##0 !svc_now;
   endsequence

   sequence s_run_idle;
      state_q == ST_RUN && !rst_wait_q && lat_q == '0;
   endsequence

   a_halt_entry: assert property (
      s_run_idle ##0 (halt_exec && !stop_exec)
      |=> state_q == ST_HALT && !cpu_clk_en && osc_run_en)
      else $error("HALT not entered with clock gated");

   a_stop_entry: assert property (
      s_run_idle ##0 (stop_exec && !irq_unmasked)
      |=> state_q == ST_STOP && !osc_run_en && !periph_run_en)
      else $error("STOP not entered with oscillator off");

   a_port_hold: assert property (
      state_q != ST_RUN |-> port_latch_hold && !cpu_clk_en)
      else $error("Port latches not held in standby");

   a_halt_gates: assert property (
      state_q == ST_HALT |-> osc_run_en && periph_run_en && !adc_can_run_en)
      else $error("HALT gating wrong");

   a_wake_service: assert property (
      s_halt_svc |=> !wake_service [*8] ##1 (wake_service && !wake_resume))
      else $error("Serviced HALT wake not at 8 clocks");

   a_wake_resume: assert property (
      s_halt_res |=> !wake_resume [*2] ##1 (wake_resume && !wake_service))
      else $error("Resumed HALT wake not at 2 clocks");

   a_nmi_wake: assert property (
      state_q == ST_HALT && nmi_req |-> ##9 wake_service)
      else $error("NMI did not force service");

   a_stop_release: assert property (
      state_q == ST_STOP && irq_unmasked |=> state_q == ST_SETTLE && osc_run_en)
      else $error("STOP not released to settle");

   a_settle_hold: assert property (
      state_q == ST_SETTLE && !sif.done |=> state_q == ST_SETTLE && !cpu_clk_en)
      else $error("Settle left before count done");

   a_count_gate: assert property (
      !osc_ok_q |-> !sif.count)
      else $error("Settle counted before oscillation");

   a_reset_exp: assert property (
      rst_wait_q |-> sif.exp_sel == EXP_W'(EXP17))
      else $error("Reset wait not at longest length");

   a_stop_pending: assert property (
      s_run_idle ##0 (stop_exec && irq_unmasked) |=> state_q == ST_SETTLE)
      else $error("Pending request did not bypass STOP");

   a_masked_hold: assert property (
      (state_q == ST_HALT || state_q == ST_STOP) && !wake_req
      |=> $stable(state_q))
      else $error("Standby left without an unmasked request");

   a_settle_exit: assert property (
      state_q == ST_SETTLE && sif.done |=> state_q == ST_RUN ##1
      (wake_service || wake_resume))
      else $error("Settle exit without wake indication");

endmodule

// ---- verification/core_model.sv ----
// Behavioural core and oscillator seen from the standby controller
`timescale 1ns/1ps
module core_model #(
   parameter int OSC_START = 10
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Controller side
   input  wire logic osc_run_en,
   input  wire logic cpu_clk_en,
   output      logic halt_exec,
   output      logic stop_exec,
   output      logic osc_running,
   // Bench requests
   input  wire logic want_halt,
   input  wire logic want_stop
);
   logic       run_s;
   logic       h_s;
   logic       s_s;
   logic       converter_run_bit;
   logic [7:0] start_cnt;

   initial begin
      halt_exec = 1'b0;
      stop_exec = 1'b0;
      osc_running = 1'b1;
      converter_run_bit = 1'b1;
      start_cnt = 8'h00;
   end

   // ---------------------------------------------------------------
   // Instruction issue and crystal start-up
   // ---------------------------------------------------------------
   always @(posedge clk_sys) begin
      run_s = osc_run_en;
      h_s = want_halt & cpu_clk_en & rst_n;
      s_s = want_stop & cpu_clk_en & rst_n;
      #1;
      halt_exec = h_s & ~s_s;
      stop_exec = s_s;
      // Software stops the converter before entry
      if (h_s | s_s) begin
         converter_run_bit = 1'b0;
      end
      // Crystal needs a start-up gap that the settle count must skip
      if (!run_s) begin
         osc_running = 1'b0;
         start_cnt = 8'h00;
      end else if (!osc_running) begin
         start_cnt = start_cnt + 8'h01;
         if (start_cnt >= OSC_START) begin
            osc_running = 1'b1;
         end
      end
   end
endmodule

// ---- verification/standby_mode_controller_bench.sv ----
// Self-checking bench for the standby mode controller
`timescale 1ns/1ps
module standby_mode_controller_bench;
   import standby_pkg::*;

   logic              clk_sys = 1'b0;
   logic              rst_n = 1'b0;
   logic              halt_exec;
   logic              stop_exec;
   logic              osc_running;
   logic              osc_run_en;
   logic              cpu_clk_en;
   logic              periph_run_en;
   logic              adc_can_run_en;
   logic              port_latch_hold;
   logic              wake_service;
   logic              wake_resume;
   logic              irq_unmasked = 1'b0;
   logic              irq_accept_enable = 1'b0;
   logic              irq_priority_flag = 1'b0;
   logic              in_service_priority = 1'b1;
   logic              nmi_req = 1'b0;
   logic              want_halt = 1'b0;
   logic              want_stop = 1'b0;
   logic [ADDR_W-1:0] reg_addr = 16'h0000;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_wdata = 8'h00;
   logic [DATA_W-1:0] rd_val;
   int                error_cnt = 0;
   int                cmp_count = 0;
   int                n;
   logic [2:0]        codes [6] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h4, 3'h3};
   int                exps [6] = '{2, 3, 4, 5, 6, 6};
   // IE, PR, IN_SERVICE_PRIORITY and whether service follows
   logic [3:0]        hrow [4] = '{4'b1001, 4'b0010, 4'b1111, 4'b1100};

   always #10 clk_sys = ~clk_sys;

   // Shortened exponents keep the settle waits in the tens of cycles
   standby_mode_controller #(.EXP12(2), .EXP14(3), .EXP15(4), .EXP16(5), .EXP17(6)) u_dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .halt_exec(halt_exec), .stop_exec(stop_exec),
      .irq_unmasked(irq_unmasked), .irq_accept_enable(irq_accept_enable),
      .irq_priority_flag(irq_priority_flag), .in_service_priority(in_service_priority),
      .nmi_req(nmi_req), .osc_running(osc_running), .osc_run_en(osc_run_en),
      .cpu_clk_en(cpu_clk_en), .periph_run_en(periph_run_en),
      .adc_can_run_en(adc_can_run_en), .port_latch_hold(port_latch_hold),
      .wake_service(wake_service), .wake_resume(wake_resume), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rd_val));

   core_model u_core (
      .clk_sys(clk_sys), .rst_n(rst_n), .osc_run_en(osc_run_en), .cpu_clk_en(cpu_clk_en),
      .halt_exec(halt_exec), .stop_exec(stop_exec), .osc_running(osc_running),
      .want_halt(want_halt), .want_stop(want_stop));

   // ---------------------------------------------------------------
   // Access and check tasks
   // ---------------------------------------------------------------
   task automatic results();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clk_sys);
      #1 reg_wr = 1'b0;
      // Idle edge so back-to-back accesses never re-raise a strobe in one step
      @(posedge clk_sys);
      #1;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp_v, input string msg);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys);
      #1 reg_rd = 1'b0;
      check(rd_val === exp_v, msg);
      @(posedge clk_sys);
      #1;
   endtask

   // Counts edges until the chosen output goes high, bounded
   task automatic wait_sig(input int which, output int cnt);
      logic s;
      cnt = 0;
      s = 1'b0;
      while (s !== 1'b1 && cnt < 2000) begin
         @(posedge clk_sys);
         #1 cnt++;
         case (which)
            0: s = cpu_clk_en;
            1: s = wake_service;
            2: s = wake_resume;
            default: s = osc_running;
         endcase
      end
   endtask

   // Issues HALT (0) or STOP (1) once the core is clocked
   task automatic enter(input bit stop);
      int k;
      k = 0;
      while (cpu_clk_en !== 1'b1 && k < 500) begin
         @(posedge clk_sys);
         #1 k++;
      end
      if (stop) want_stop = 1'b1;
      else want_halt = 1'b1;
      @(posedge clk_sys);
      #1 want_halt = 1'b0;
      want_stop = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      results();
   end

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_sys);
      #1;
      check(cpu_clk_en === 1'b0 && port_latch_hold === 1'b1, "reset gate");
      check(osc_run_en === 1'b1 && adc_can_run_en === 1'b0, "reset osc");
      rst_n = 1'b1;
      wait_sig(0, n);
      check(n >= 64 && n <= 70, "reset settle length");
      rd(SETTLE_ADDR, 8'h04, "select reset value");
      rd(16'h0000, 8'h00, "unmapped read");
      wr(16'h0000, 8'h01);
      rd(SETTLE_ADDR, 8'h04, "unmapped write leaked");
      // Each valid code, then prohibited code 3 last, through a full STOP cycle
      for (int i = 0; i < 6; i++) begin
         wr(SETTLE_ADDR, {5'h00, codes[i]});
         rd(SETTLE_ADDR, {5'h00, codes[i]}, "select readback");
         irq_accept_enable = 1'b1;
         irq_priority_flag = 1'b0;
         enter(1'b1);
         check(osc_run_en === 1'b0 && cpu_clk_en === 1'b0, "stop entry");
         check(periph_run_en === 1'b0 && port_latch_hold === 1'b1, "stop gates");
         repeat (10) @(posedge clk_sys);
         #1 check(osc_run_en === 1'b0, "stop left without request");
         irq_unmasked = 1'b1;
         wait_sig(3, n);
         wait_sig(0, n);
         check(n >= (1 << exps[i]) && n <= (1 << exps[i]) + 5, "stop settle");
         // Wake pulse stands only in the cycle the CPU clock returns
         check(wake_service === 1'b1 && wake_resume === 1'b0, "stop wake service");
         irq_unmasked = 1'b0;
      end
      // HALT wake-up by each acknowledge case
      for (int i = 0; i < 4; i++) begin
         {irq_accept_enable, irq_priority_flag, in_service_priority} = hrow[i][3:1];
         enter(1'b0);
         check(cpu_clk_en === 1'b0 && osc_run_en === 1'b1, "halt gates");
         check(periph_run_en === 1'b1 && adc_can_run_en === 1'b0, "halt units");
         check(port_latch_hold === 1'b1, "halt port hold");
         repeat (5) @(posedge clk_sys);
         #1 check(cpu_clk_en === 1'b0, "halt left while masked");
         irq_unmasked = 1'b1;
         wait_sig(hrow[i][0] ? 1 : 2, n);
         if (hrow[i][0]) check(n >= 8 && n <= 9, "halt service latency");
         else check(n >= 2 && n <= 3, "halt resume latency");
         irq_unmasked = 1'b0;
      end
      irq_accept_enable = 1'b0;
      enter(1'b0);
      nmi_req = 1'b1;
      wait_sig(1, n);
      check(n >= 8 && n <= 9, "nmi halt release");
      nmi_req = 1'b0;
      // STOP with a request already pending falls into the settle wait
      wr(SETTLE_ADDR, 8'h00);
      irq_unmasked = 1'b1;
      enter(1'b1);
      check(osc_run_en === 1'b1 && cpu_clk_en === 1'b0, "pending stop");
      wait_sig(0, n);
      check(n >= 1 && n <= 8, "pending stop settle");
      irq_unmasked = 1'b0;
      // Reset out of STOP ignores the short code
      enter(1'b1);
      repeat (3) @(posedge clk_sys);
      #1 rst_n = 1'b0;
      repeat (3) @(posedge clk_sys);
      #1 check(osc_run_en === 1'b1 && cpu_clk_en === 1'b0, "reset in stop");
      rst_n = 1'b1;
      wait_sig(0, n);
      check(n >= 64 && n <= 80, "stop reset settle");
      results();
   end
endmodule
